// >>> rtl/plbl_top.sv
// Purpose: Labels requests with a partition bundle, caches it per line, re-attaches it on eviction.
// Assumes: Single clock, synchronous inputs, one request per cycle, answers one cycle later.
// Notes: The cache is direct mapped and abstract; data itself is not held here.
module plbl_top
  import plbl_pkg::*;
#(
  parameter int MAX_PART = 15,
  parameter int MAX_GRP = 1,
  parameter int VMAP_N = 4,
  parameter int AW = 32,
  parameter int OFF_W = 6,
  parameter int IDX_W = 3,
  parameter bit FOUR_SPACE = 1'b1,
  parameter bit VIRT_EN = 1'b1
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic req_valid_i,
  input wire logic [1:0] req_src_i,
  input wire logic [AW-1:0] req_addr_i,
  input wire logic req_write_i,
  input wire logic [1:0] req_lvl_i,
  input wire logic [1:0] req_space_i,
  input wire logic [$clog2(MAX_PART+1)-1:0] in_part_i,
  input wire logic [$clog2(MAX_GRP+1)-1:0] in_grp_i,
  input wire logic [1:0] in_space_i,
  output logic hit_o,
  output logic down_valid_o,
  output logic [AW-1:0] down_addr_o,
  output logic down_write_o,
  output logic [$clog2(MAX_PART+1)-1:0] down_part_o,
  output logic [$clog2(MAX_GRP+1)-1:0] down_grp_o,
  output logic down_ns_o,
  output logic [1:0] down_sp_o,
  output logic [PRIO_W-1:0] down_prio_o,
  output logic evict_valid_o,
  output logic [AW-1:0] evict_addr_o,
  output logic [$clog2(MAX_PART+1)-1:0] evict_part_o,
  output logic [$clog2(MAX_GRP+1)-1:0] evict_grp_o,
  output logic evict_ns_o,
  output logic [1:0] evict_sp_o
);
  // Widths follow the system maxima so every port agrees.
  localparam int PW = $clog2(MAX_PART + 1);
  localparam int GW = $clog2(MAX_GRP + 1);
  localparam int NPART = MAX_PART + 1;
  localparam int NL = 1 << IDX_W;
  localparam int TW = AW - OFF_W - IDX_W;
  localparam int VW = (VMAP_N > 1) ? $clog2(VMAP_N) : 1;
  localparam int CW = IDX_W + 1;
  localparam logic [31:0] PART_MASK = (32'h1 << PW) - 32'h1;
  localparam logic [31:0] GRP_MASK = ((32'h1 << GW) - 32'h1) << GRP_LSB;
  localparam logic [31:0] SPC_MASK = 32'h3 << SPC_LSB;
  localparam logic [31:0] LVL_MASK = (32'h1 << EN_BIT) | (32'h1 << VEN_BIT) | GRP_MASK | PART_MASK;
  localparam logic [31:0] SET_MASK = (32'h1 << ALLOC_BIT) | (32'h3 << PRIO_LSB);
  localparam logic [31:0] MSEL_MASK = GRP_MASK | PART_MASK;
  localparam logic [31:0] DMA_MASK = SPC_MASK | GRP_MASK | PART_MASK;

  logic [31:0] lvl_reg [NUM_LVL];
  logic [PW-1:0] vmap_reg [VMAP_N];
  logic [31:0] set_reg [NPART];
  logic [31:0] msel_reg;
  logic [31:0] dma_reg;
  logic [31:0] rd_next;
  logic [TW-1:0] tag_reg [NL];
  logic vld_reg [NL];
  logic [PW-1:0] pn_reg [NL];
  logic [GW-1:0] grp_reg [NL];
  logic [1:0] sp_reg [NL];

  logic [PW-1:0] l_part;
  logic [GW-1:0] l_grp;
  logic [1:0] l_sp;
  logic [31:0] cur_lvl;
  logic [PW-1:0] vpart;
  logic [IDX_W-1:0] idx;
  logic [TW-1:0] tag;
  logic cacheable;
  logic hit;
  logic alloc_ok;
  logic do_alloc;
  logic fwd;
  logic evict;
  logic [PW-1:0] victim_part;
  logic [CW-1:0] mon_cnt;

  // Byte address of word i of a register group.
  function automatic logic reg_at(input logic [7:0] a, input logic [7:0] base, input int i);
    reg_at = (a == base + 8'(WORD_BYTES * i));
  endfunction

  // A two-space region only knows secure and nonsecure.
  function automatic logic [1:0] norm_sp(input logic [1:0] s);
    norm_sp = FOUR_SPACE ? s : ((s == SP_NS) ? SP_NS : SP_SEC);
  endfunction

  // Register writes; reserved bits are masked away so they read as zero.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_LVL; i++) begin
        lvl_reg[i] <= ZERO_WORD;
      end
    end else if (ce_i && reg_wr_i) begin
      for (int i = 0; i < NUM_LVL; i++) begin
        if (reg_at(reg_addr_i, OFS_LVL, i)) begin
          lvl_reg[i] <= reg_wdata_i & LVL_MASK;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < VMAP_N; i++) begin
        vmap_reg[i] <= PW'(DEF_PART);
      end
    end else if (ce_i && reg_wr_i) begin
      for (int i = 0; i < VMAP_N; i++) begin
        if (reg_at(reg_addr_i, OFS_VMAP, i)) begin
          vmap_reg[i] <= reg_wdata_i[PW-1:0];
        end
      end
    end
  end

  // One settings word per partition: allocation enable and priority.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < NPART; i++) begin
        set_reg[i] <= SET_RST;
      end
    end else if (ce_i && reg_wr_i) begin
      for (int i = 0; i < NPART; i++) begin
        if (reg_at(reg_addr_i, OFS_SET, i)) begin
          set_reg[i] <= reg_wdata_i & SET_MASK;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      msel_reg <= ZERO_WORD;
      dma_reg <= ZERO_WORD;
    end else if (ce_i && reg_wr_i) begin
      if (reg_at(reg_addr_i, OFS_MSEL, 0)) begin
        msel_reg <= reg_wdata_i & MSEL_MASK;
      end
      if (reg_at(reg_addr_i, OFS_DMA, 0)) begin
        dma_reg <= reg_wdata_i & DMA_MASK;
      end
    end
  end

  // Occupancy monitor: lines held by the selected partition and group.
  always_comb begin
    mon_cnt = '0;
    for (int i = 0; i < NL; i++) begin
      if (vld_reg[i] && pn_reg[i] == msel_reg[PW-1:0]
          && grp_reg[i] == msel_reg[GRP_LSB +: GW]) begin
        mon_cnt = mon_cnt + CW'(1);
      end
    end
  end

  always_comb begin
    rd_next = ZERO_WORD;
    for (int i = 0; i < NUM_LVL; i++) begin
      if (reg_at(reg_addr_i, OFS_LVL, i)) begin
        rd_next = lvl_reg[i];
      end
    end
    for (int i = 0; i < VMAP_N; i++) begin
      if (reg_at(reg_addr_i, OFS_VMAP, i)) begin
        rd_next = 32'(vmap_reg[i]);
      end
    end
    for (int i = 0; i < NPART; i++) begin
      if (reg_at(reg_addr_i, OFS_SET, i)) begin
        rd_next = set_reg[i];
      end
    end
    if (reg_at(reg_addr_i, OFS_MSEL, 0)) begin
      rd_next = msel_reg;
    end
    if (reg_at(reg_addr_i, OFS_MCNT, 0)) begin
      rd_next = 32'(mon_cnt);
    end
    if (reg_at(reg_addr_i, OFS_ID, 0)) begin
      // Software discovers the maxima to keep the system consistent.
      rd_next = (32'(MAX_GRP) << ID_GRP_LSB) | 32'(MAX_PART);
    end
    if (reg_at(reg_addr_i, OFS_DMA, 0)) begin
      rd_next = dma_reg;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o <= ZERO_WORD;
    end else if (ce_i) begin
      reg_rdata_o <= reg_rd_i ? rd_next : ZERO_WORD;
    end
  end

  // Label generation per source.
  always_comb begin
    cur_lvl = lvl_reg[req_lvl_i];
    vpart = cur_lvl[PW-1:0];
    l_part = PW'(DEF_PART);
    l_grp = GW'(DEF_GRP);
    l_sp = in_space_i;
    unique case (req_src_i)
      SRC_PE: begin
        l_sp = req_space_i;
        if (cur_lvl[EN_BIT]) begin
          l_part = vpart;
          l_grp = cur_lvl[GRP_LSB +: GW];
          if (VIRT_EN && cur_lvl[VEN_BIT] && req_lvl_i <= LVL_VIRT_TOP) begin
            // Out-of-range virtual numbers fall back to the default.
            l_part = (32'(vpart) < VMAP_N) ? vmap_reg[VW'(vpart)] : PW'(DEF_PART);
          end
        end
      end
      SRC_DMA: begin
        l_part = dma_reg[PW-1:0];
        l_grp = dma_reg[GRP_LSB +: GW];
        l_sp = dma_reg[SPC_LSB +: 2];
      end
      default: begin
        l_part = in_part_i;
        l_grp = in_grp_i;
      end
    endcase
    l_sp = norm_sp(l_sp);
  end

  assign idx = req_addr_i[OFF_W +: IDX_W];
  assign tag = req_addr_i[AW-1 -: TW];
  assign cacheable = (req_src_i != SRC_FWD);
  // The tag match ignores the partition, so any partition may reach any address.
  assign hit = vld_reg[idx] && (tag_reg[idx] == tag);
  assign alloc_ok = (32'(l_part) < NPART) && set_reg[l_part][ALLOC_BIT];
  assign do_alloc = req_valid_i && cacheable && !hit && alloc_ok;
  // Hits and absorbed inner evictions end here without going downstream.
  assign fwd = req_valid_i && !(cacheable && hit) && !(req_src_i == SRC_INNER && do_alloc);
  assign evict = do_alloc && vld_reg[idx];
  assign victim_part = pn_reg[idx];

  // Line store; the allocating request's bundle becomes the line's property.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < NL; i++) begin
        vld_reg[i] <= 1'b0;
        tag_reg[i] <= '0;
        pn_reg[i] <= PW'(DEF_PART);
        grp_reg[i] <= GW'(DEF_GRP);
        sp_reg[i] <= SP_SEC;
      end
    end else if (ce_i && do_alloc) begin
      vld_reg[idx] <= 1'b1;
      tag_reg[idx] <= tag;
      pn_reg[idx] <= l_part;
      grp_reg[idx] <= l_grp;
      sp_reg[idx] <= l_sp;
    end
  end

  // Downstream request, labelled with the request's own bundle.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hit_o <= 1'b0;
      down_valid_o <= 1'b0;
      down_addr_o <= '0;
      down_write_o <= 1'b0;
      down_part_o <= '0;
      down_grp_o <= '0;
      down_ns_o <= 1'b0;
      down_sp_o <= SP_SEC;
      down_prio_o <= '0;
    end else if (ce_i) begin
      hit_o <= req_valid_i && cacheable && hit;
      down_valid_o <= fwd;
      down_addr_o <= req_addr_i;
      down_write_o <= req_write_i;
      down_part_o <= l_part;
      down_grp_o <= l_grp;
      down_ns_o <= (l_sp == SP_NS);
      down_sp_o <= l_sp;
      // Priority taken from the issuing partition's settings.
      down_prio_o <= (32'(l_part) < NPART) ? set_reg[l_part][PRIO_LSB +: PRIO_W] : '0;
    end
  end

  // Eviction of the victim carries the bundle stored with it.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      evict_valid_o <= 1'b0;
      evict_addr_o <= '0;
      evict_part_o <= '0;
      evict_grp_o <= '0;
      evict_ns_o <= 1'b0;
      evict_sp_o <= SP_SEC;
    end else if (ce_i) begin
      evict_valid_o <= evict;
      evict_addr_o <= {tag_reg[idx], idx, OFF_W'(0)};
      evict_part_o <= victim_part;
      evict_grp_o <= grp_reg[idx];
      evict_ns_o <= (sp_reg[idx] == SP_NS);
      evict_sp_o <= sp_reg[idx];
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_HIT_LOCAL: assert property (
    ce_i && req_valid_i && cacheable && hit |=> hit_o && !down_valid_o)
    else $error("hit was forwarded or not answered");
  AST_MISS_FWD: assert property (
    ce_i && req_valid_i && req_src_i != SRC_INNER && !hit |=> down_valid_o && !hit_o)
    else $error("miss not forwarded downstream");
  AST_ALLOC_STORE: assert property (
    ce_i && do_alloc |=> vld_reg[$past(idx)] && pn_reg[$past(idx)] == $past(l_part)
      && sp_reg[$past(idx)] == $past(l_sp))
    else $error("allocated line lost its bundle");
  AST_EVICT_LABEL: assert property (
    ce_i && evict |=> evict_valid_o && evict_part_o == $past(victim_part))
    else $error("eviction without stored partition");
  AST_INNER_KEEP: assert property (
    ce_i && req_src_i == SRC_INNER && do_alloc |=> pn_reg[$past(idx)] == $past(in_part_i)
      && !down_valid_o)
    else $error("inner eviction partition not kept");
  AST_ALLOC_GATE: assert property (
    ce_i && req_valid_i && cacheable && !hit && !alloc_ok |=> down_valid_o && !evict_valid_o)
    else $error("allocation not gated by settings");
  AST_FWD_PASS: assert property (
    ce_i && req_valid_i && req_src_i == SRC_FWD |=> down_valid_o
      && down_part_o == $past(in_part_i) && down_grp_o == $past(in_grp_i))
    else $error("routed bundle altered");
  AST_DEF_PART: assert property (
    ce_i && req_valid_i && req_src_i == SRC_PE && !cur_lvl[EN_BIT]
      |=> down_part_o == PW'(DEF_PART) && down_grp_o == GW'(DEF_GRP))
    else $error("disabled level not defaulted");
  AST_NS_BIT: assert property (
    down_valid_o |-> down_ns_o == (down_sp_o == SP_NS))
    else $error("nonsecure bit disagrees with space");
  AST_PE_LABEL: assert property (
    ce_i && req_valid_i && req_src_i == SRC_PE && cur_lvl[EN_BIT] && !cur_lvl[VEN_BIT]
      |=> down_part_o == $past(vpart) && down_sp_o == norm_sp($past(req_space_i)))
    else $error("processing element label wrong");

  COV_HIT: cover property (ce_i && req_valid_i && cacheable && hit);
  COV_EVICT: cover property (ce_i && evict ##1 evict_valid_o);
  COV_VIRT: cover property (ce_i && req_valid_i && req_src_i == SRC_PE && cur_lvl[VEN_BIT]);
  COV_INNER: cover property (ce_i && req_src_i == SRC_INNER && do_alloc);
endmodule

// >>> rtl/plbl_pkg.sv
// Purpose: Shared constants for the partition label propagation block.
// Assumes: 32-bit register port with byte addresses, one aligned word per register.
// Notes: Space codes, source codes and register field positions live here.
package plbl_pkg;
  localparam logic [7:0] OFS_LVL = 8'h00;
  localparam logic [7:0] OFS_VMAP = 8'h10;
  localparam logic [7:0] OFS_SET = 8'h40;
  localparam logic [7:0] OFS_MSEL = 8'h80;
  localparam logic [7:0] OFS_MCNT = 8'h84;
  localparam logic [7:0] OFS_ID = 8'h88;
  localparam logic [7:0] OFS_DMA = 8'h8c;
  localparam int NUM_LVL = 4;
  localparam int WORD_BYTES = 4;
  localparam int GRP_LSB = 8;
  localparam int VEN_BIT = 16;
  localparam int EN_BIT = 31;
  localparam int SPC_LSB = 20;
  localparam int ALLOC_BIT = 0;
  localparam int PRIO_LSB = 4;
  localparam int PRIO_W = 2;
  localparam int ID_GRP_LSB = 16;
  localparam logic [31:0] SET_RST = 32'h0000_0001;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0] SP_SEC = 2'h0;
  localparam logic [1:0] SP_NS = 2'h1;
  localparam logic [1:0] SP_ROOT = 2'h2;
  localparam logic [1:0] SP_REALM = 2'h3;
  localparam logic [1:0] SRC_PE = 2'h0;
  localparam logic [1:0] SRC_DMA = 2'h1;
  localparam logic [1:0] SRC_INNER = 2'h2;
  localparam logic [1:0] SRC_FWD = 2'h3;
  localparam logic [1:0] LVL_VIRT_TOP = 2'h1;
  localparam int DEF_PART = 0;
  localparam int DEF_GRP = 0;
endpackage

// >>> testbench/plbl_down_model.sv
// Purpose: Downstream completer model that terminates labelled requests from the block.
// Assumes: One request per cycle, no backpressure, bundle meaningful while valid is high.
// Notes: It keeps a count and the last bundle so the bench can see what arrived.
module plbl_down_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input wire logic [3:0] part_i,
  input wire logic grp_i,
  input wire logic [1:0] sp_i,
  output int count_o,
  output logic [6:0] last_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // The bundle is consumed here and never sent further, as a memory channel would.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count_o <= 0;
      last_o <= 7'h00;
    end else if (valid_i) begin
      count_o <= count_o + 1;
      last_o <= {part_i, grp_i, sp_i};
    end
  end
endmodule

// >>> testbench/plbl_top_bench.sv
// Purpose: Self-checking bench for the partition label block.
// Assumes: Default widths, four spaces and virtualization enabled.
// Notes: Each request is sampled one cycle after it is taken, as the outputs are registered.
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; \
  $display("FAIL %s exp %h got %h", nm, e, s); end end
module plbl_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import plbl_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr = 1'b0, rd = 1'b0, rv = 1'b0;
  logic ce = 1'b1, wq = 1'b0, dwr;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h0, ad = 32'h0, rdata, eaddr, daddr;
  logic [1:0] src = 2'h0, lv = 2'h0, sp = 2'h0, dsp, esp;
  logic [3:0] ip = 4'h0, dpart, epart;
  logic ig = 1'b0, hit, dv, ev, dgrp, dns, egrp, ens;
  logic [1:0] prio;
  logic [6:0] last;
  int fails = 0, num_checks = 0, cnt;
  always #5 clock_i = ~clock_i;
  plbl_top #(.MAX_PART(15), .MAX_GRP(1)) DUT (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce),
    .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .req_valid_i(rv), .req_src_i(src), .req_addr_i(ad), .req_write_i(wq), .req_lvl_i(lv),
    .req_space_i(sp), .in_part_i(ip), .in_grp_i(ig), .in_space_i(sp), .hit_o(hit),
    .down_valid_o(dv), .down_addr_o(daddr), .down_write_o(dwr), .down_part_o(dpart),
    .down_grp_o(dgrp), .down_ns_o(dns), .down_sp_o(dsp), .down_prio_o(prio),
    .evict_valid_o(ev), .evict_addr_o(eaddr), .evict_part_o(epart), .evict_grp_o(egrp),
    .evict_ns_o(ens), .evict_sp_o(esp));
  plbl_down_model far (.clock_i(clock_i), .rst_i(rst_i), .valid_i(dv), .part_i(dpart),
    .grp_i(dgrp), .sp_i(dsp), .count_o(cnt), .last_o(last));
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr <= w;
    rd <= !w;
    ra <= a;
    wd <= d;
    @(posedge clock_i);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rw(1'b0, a, 32'h0);
    `CHK("rdata", e, rdata)
  endtask
  task automatic req(input logic [1:0] s, input logic [31:0] a, input logic [1:0] l,
                     input logic [1:0] spc, input logic [3:0] p, input logic g);
    @(posedge clock_i);
    rv <= 1'b1;
    src <= s;
    ad <= a;
    lv <= l;
    sp <= spc;
    ip <= p;
    ig <= g;
    @(posedge clock_i);
    rv <= 1'b0;
    #1;
  endtask
  // Flags are {hit, down valid, evict valid}; the label is only meaningful on a forward.
  task automatic look(input logic [2:0] f, input logic [6:0] lab);
    `CHK("flags", f, {hit, dv, ev})
    if (f[1]) begin
      `CHK("label", lab, {dpart, dgrp, dsp})
      `CHK("ns", lab[1:0] == SP_NS, dns)
      `CHK("addr", ad, daddr)
      `CHK("write", wq, dwr)
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clock_i);
    fails++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    rchk(OFS_ID, 32'h0001_000f);
    rchk(OFS_SET, SET_RST);
    rchk(8'h9c, ZERO_WORD);
    rchk(OFS_MCNT, ZERO_WORD);
    $display("test registers done");
    req(SRC_PE, 32'h1000, 2'h2, SP_NS, 4'h0, 1'b0);
    look(3'b010, {4'h0, 1'b0, SP_NS});
    rw(1'b1, OFS_LVL + 8'h08, 32'h8000_0105);
    req(SRC_PE, 32'h2000, 2'h2, SP_ROOT, 4'h0, 1'b0);
    look(3'b011, {4'h5, 1'b1, SP_ROOT});
    `CHK("evict addr", 32'h1000, eaddr)
    `CHK("evict", {4'h0, 1'b0, SP_NS, 1'b1}, {epart, egrp, esp, ens})
    req(SRC_PE, 32'h2000, 2'h0, SP_SEC, 4'h0, 1'b0);
    look(3'b100, 7'h00);
    rw(1'b1, OFS_MSEL, 32'h0000_0105);
    rchk(OFS_MCNT, 32'h0000_0001);
    // A write while the clock enable is low must leave the register untouched.
    @(posedge clock_i);
    ce <= 1'b0;
    rw(1'b1, OFS_MSEL, 32'h0000_0002);
    @(posedge clock_i);
    ce <= 1'b1;
    rchk(OFS_MSEL, 32'h0000_0105);
    $display("test label and hit done");
    rw(1'b1, OFS_LVL + 8'h04, 32'h8001_0002);
    rw(1'b1, OFS_VMAP + 8'h08, 32'h0000_0009);
    req(SRC_PE, 32'h1040, 2'h1, SP_REALM, 4'h0, 1'b0);
    look(3'b010, {4'h9, 1'b0, SP_REALM});
    $display("test virtual mapping done");
    req(SRC_INNER, 32'h1080, 2'h0, SP_NS, 4'h7, 1'b1);
    look(3'b000, 7'h00);
    req(SRC_FWD, 32'h1080, 2'h0, SP_SEC, 4'h3, 1'b0);
    look(3'b010, {4'h3, 1'b0, SP_SEC});
    @(posedge clock_i);
    wq <= 1'b1;
    req(SRC_FWD, 32'h3000, 2'h0, SP_NS, 4'h0, 1'b0);
    look(3'b010, {4'h0, 1'b0, SP_NS});
    @(posedge clock_i);
    wq <= 1'b0;
    req(SRC_PE, 32'h2080, 2'h0, SP_SEC, 4'h0, 1'b0);
    look(3'b011, {4'h0, 1'b0, SP_SEC});
    `CHK("evict", {4'h7, 1'b1, SP_NS}, {epart, egrp, esp})
    $display("test inner eviction done");
    rw(1'b1, OFS_DMA, 32'h0030_010c);
    req(SRC_DMA, 32'h10c0, 2'h0, SP_SEC, 4'h0, 1'b0);
    look(3'b010, {4'hc, 1'b1, SP_REALM});
    rw(1'b1, OFS_SET + 8'h30, 32'h0000_0020);
    rchk(OFS_SET + 8'h30, 32'h0000_0020);
    repeat (2) begin
      req(SRC_DMA, 32'h20c0, 2'h0, SP_SEC, 4'h0, 1'b0);
      look(3'b010, {4'hc, 1'b1, SP_REALM});
      `CHK("prio", 2'h2, prio)
    end
    req(SRC_DMA, 32'h10c0, 2'h0, SP_SEC, 4'h0, 1'b0);
    look(3'b100, 7'h00);
    `CHK("down count", 9, cnt)
    `CHK("down last", {4'hc, 1'b1, SP_REALM}, last)
    $display("test settings done");
    conclude();
  end
endmodule
